// ### dsl_map.svh
// Purpose: constants for the sample input latch
// Assumes: 25 MHz system clock
// Notes: times in ns, counts derived in cycles
`ifndef DSL_MAP_SVH
`define DSL_MAP_SVH
`define DSL_DATA_W 12
`define DSL_FULL_CODE 12'hfff
`define DSL_ZERO_CODE 12'h000
`define DSL_CLK_NS 40
`define DSL_MAX_RATE_MSPS 210
`define DSL_PDN_NS 50
`define DSL_PUP_NS 5000
// Longest time rounds down, at least one cycle
`define DSL_PDN_CYC ((`DSL_PDN_NS / `DSL_CLK_NS) < 1 ? 1 : (`DSL_PDN_NS / `DSL_CLK_NS))
// Least time rounds up
`define DSL_PUP_CYC ((`DSL_PUP_NS + `DSL_CLK_NS - 1) / `DSL_CLK_NS)
`define DSL_CNT_W 8
`define DSL_MODE_SE 2'h0
`define DSL_MODE_HIZ 2'h1
`define DSL_MODE_PECL 2'h2
`endif

// ### dsl_pkg.sv
// Purpose: types for the sample input latch
// Assumes: none
// Notes: strap level coding and clock receiver modes
`default_nettype none
package dsl_pkg;
    // Strap level as seen by a three-level detector
    typedef enum logic [1:0] {
        DSL_STRAP_LOW,
        DSL_STRAP_HIGH,
        DSL_STRAP_FLOAT
    } dsl_strap_t;
    // Clock receiver mode
    typedef enum logic [1:0] {
        DSL_CLK_SINGLE,
        DSL_CLK_DIFF_HIZ,
        DSL_CLK_DIFF_PECL
    } dsl_clk_mode_t;
    // Power state
    typedef enum logic [1:0] {
        DSL_PWR_ON,
        DSL_PWR_DOWN,
        DSL_PWR_OFF,
        DSL_PWR_UP
    } dsl_pwr_t;
endpackage
`default_nettype wire

// ### dsl_pwr_if.sv
// Purpose: carrier between latch top and power sequencer
// Assumes: one clock domain
// Notes: sleep level in, state and valid flags out
`timescale 1ns/1ps
`default_nettype none
interface dsl_pwr_if;
    logic sleep;        // Synchronised sleep level
    logic current_on;   // Output current sources enabled
    logic out_valid;    // Output settled and valid
    modport seq (input sleep, output current_on, output out_valid);
    modport top (output sleep, input current_on, input out_valid);
endinterface
`default_nettype wire

// ### dsl_pwr_seq.sv
// Purpose: sleep power sequencer
// Assumes: sleep already synchronised
// Notes: power-up timing counted in clocks; power-down is one fixed DOWN state
`timescale 1ns/1ps
`default_nettype none
`include "dsl_map.svh"
module dsl_pwr_seq (
    input wire logic i_clk,
    input wire logic i_rst,
    dsl_pwr_if.seq pwr
);
    import dsl_pkg::*;
    //--------------------------------------------
    // Sequencer state
    //--------------------------------------------
    dsl_pwr_t state; // Current power state
    dsl_pwr_t next_state;
    logic [`DSL_CNT_W-1:0] cnt; // Cycle counter
    logic [`DSL_CNT_W-1:0] next_cnt;
    logic current_on;
    logic next_current_on;
    logic out_valid;
    logic next_out_valid;

    // Next state logic
    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_current_on = current_on;
        next_out_valid = out_valid;
        case (state)
            DSL_PWR_ON: begin
                if (pwr.sleep) begin
                    next_state = DSL_PWR_DOWN;
                    next_out_valid = 1'b0;
                    next_cnt = `DSL_CNT_W'(`DSL_PDN_CYC - 1);
                end
            end
            DSL_PWR_DOWN: begin
                next_current_on = 1'b0;
                next_state = DSL_PWR_OFF;
            end
            DSL_PWR_OFF: begin
                if (!pwr.sleep) begin
                    next_state = DSL_PWR_UP;
                    next_current_on = 1'b1;
                    next_cnt = `DSL_CNT_W'(`DSL_PUP_CYC - 1);
                end
            end
            DSL_PWR_UP: begin
                if (pwr.sleep) begin
                    next_state = DSL_PWR_DOWN;
                end else if (cnt == `DSL_CNT_W'(0)) begin
                    next_state = DSL_PWR_ON;
                    next_out_valid = 1'b1;
                end else begin
                    next_cnt = cnt - `DSL_CNT_W'(1);
                end
            end
            default: begin
                next_state = DSL_PWR_ON;
            end
        endcase
    end

    // State registers
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            state <= DSL_PWR_ON;
            cnt <= `DSL_CNT_W'(0);
            current_on <= 1'b1;
            out_valid <= 1'b1;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            current_on <= next_current_on;
            out_valid <= next_out_valid;
        end
    end

    assign pwr.current_on = current_on;
    assign pwr.out_valid = out_valid;

    a_pdn_time: assert property (@(posedge i_clk) disable iff (i_rst)
        (state == DSL_PWR_ON && pwr.sleep) |-> ##2 !current_on)
        else $error("power-down too slow");
endmodule
`default_nettype wire

// ### dsl_sample_latch.sv
// Purpose: sample word latch and converter control for a 12-bit current converter
// Assumes: sample source and strap pins outside clock domain
// Notes: strap caught after reset release, so reset must span two clocks;
//        sleep pull-down modelled as a zero default
`timescale 1ns/1ps
`default_nettype none
`include "dsl_map.svh"

// Functional notes
// - 12-bit straight binary, bit 11 is MSB
// - all ones gives full true current
// - word latched, output updates on rising edge
// - new word every clock edge
// - strap selects clock receiver mode
// - sleep high powers down current
// - sleep pulled down, stays enabled
// - down under 50 ns, up 5 us; current here turns off three clocks (120 ns) after synchronised sleep
module dsl_sample_latch (
    input wire logic I_MCLK,
    input wire logic I_RST,
    input wire logic [`DSL_DATA_W-1:0] i_SAMPLE,
    input wire logic i_SLEEP,
    input wire logic i_SLEEP_DRIVEN,
    input wire dsl_pkg::dsl_strap_t i_CLOCK_MODE_STRAP,
    output logic [`DSL_DATA_W-1:0] o_CURRENT_OUT_TRUE,
    output logic [`DSL_DATA_W-1:0] o_CURRENT_OUT_COMP,
    output dsl_pkg::dsl_clk_mode_t o_CLOCK_MODE,
    output logic o_PECL_TERM_ON,
    output logic o_CURRENT_ON,
    output logic o_OUT_VALID
);
    import dsl_pkg::*;

    //--------------------------------------------
    // Helper functions
    //--------------------------------------------
    // Complementary code: remainder of full scale
    function automatic logic [`DSL_DATA_W-1:0] comp_code(input logic [`DSL_DATA_W-1:0] c);
        comp_code = `DSL_FULL_CODE - c;
    endfunction

    // Strap level to clock receiver mode
    function automatic dsl_clk_mode_t strap_mode(input dsl_strap_t s);
        if (s == DSL_STRAP_LOW) begin
            strap_mode = DSL_CLK_SINGLE;
        end else if (s == DSL_STRAP_HIGH) begin
            strap_mode = DSL_CLK_DIFF_HIZ;
        end else begin
            strap_mode = DSL_CLK_DIFF_PECL;
        end
    endfunction

    //--------------------------------------------
    // Input synchronisers
    //--------------------------------------------
    logic [`DSL_DATA_W-1:0] samp_s1; // First stage, sample
    logic [`DSL_DATA_W-1:0] samp_s2; // Second stage, sample
    logic sleep_s1;
    logic sleep_s2;
    dsl_strap_t strap_s1;
    dsl_strap_t strap_s2;
    logic sleep_lvl; // Effective sleep after pull-down

    // Two-stage capture of outside pins
    always_ff @(posedge I_MCLK or posedge I_RST) begin
        if (I_RST) begin
            samp_s1 <= `DSL_ZERO_CODE;
            samp_s2 <= `DSL_ZERO_CODE;
            sleep_s1 <= 1'b0;
            sleep_s2 <= 1'b0;
        end else begin
            // source times data to falling edge
            samp_s1 <= i_SAMPLE;
            samp_s2 <= samp_s1;
            sleep_s1 <= i_SLEEP_DRIVEN & i_SLEEP;
            sleep_s2 <= sleep_s1;
        end
    end
    assign sleep_lvl = sleep_s2;

    // Strap capture runs through reset, so the second stage
    // already holds the pin level at the first edge after release
    always_ff @(posedge I_MCLK) begin
        strap_s1 <= i_CLOCK_MODE_STRAP;
        strap_s2 <= strap_s1;
    end

    //--------------------------------------------
    // Power sequencer
    //--------------------------------------------
    dsl_pwr_if pwr ();
    assign pwr.sleep = sleep_lvl;

    dsl_pwr_seq u_seq (
        .i_clk(I_MCLK),
        .i_rst(I_RST),
        .pwr(pwr)
    );

    //--------------------------------------------
    // Strap capture after reset
    //--------------------------------------------
    logic strap_done;
    logic next_strap_done;
    dsl_clk_mode_t mode;
    dsl_clk_mode_t next_mode;
    logic pecl;
    logic next_pecl;

    // Mode decided once after release
    always_comb begin
        next_strap_done = strap_done;
        next_mode = mode;
        next_pecl = pecl;
        if (!strap_done) begin
            next_mode = strap_mode(strap_s2);
            // negative input unused in single mode
            next_pecl = (strap_mode(strap_s2) == DSL_CLK_DIFF_PECL);
            next_strap_done = 1'b1;
        end
    end

    // Strap registers
    always_ff @(posedge I_MCLK or posedge I_RST) begin
        if (I_RST) begin
            strap_done <= 1'b0;
            mode <= DSL_CLK_SINGLE;
            pecl <= 1'b0;
        end else begin
            strap_done <= next_strap_done;
            mode <= next_mode;
            pecl <= next_pecl;
        end
    end

    //--------------------------------------------
    // Master/slave sample latch
    //--------------------------------------------
    logic [`DSL_DATA_W-1:0] master;
    logic [`DSL_DATA_W-1:0] next_master;
    logic [`DSL_DATA_W-1:0] out_true;
    logic [`DSL_DATA_W-1:0] next_out_true;
    logic [`DSL_DATA_W-1:0] out_comp;
    logic [`DSL_DATA_W-1:0] next_out_comp;

    // Next latch and output codes
    always_comb begin
        // master takes word each rising edge
        next_master = samp_s2;
        if (pwr.current_on) begin
            // straight binary, MSB is bit 11
            next_out_true = master;
            next_out_comp = comp_code(master);
        end else begin
            next_out_true = `DSL_ZERO_CODE;
            next_out_comp = `DSL_ZERO_CODE;
        end
    end

    // Master and slave registers
    always_ff @(posedge I_MCLK or posedge I_RST) begin
        if (I_RST) begin
            master <= `DSL_ZERO_CODE;
            out_true <= `DSL_ZERO_CODE;
            out_comp <= `DSL_FULL_CODE;
        end else begin
            master <= next_master;
            out_true <= next_out_true;
            out_comp <= next_out_comp;
        end
    end

    //--------------------------------------------
    // Status flops
    //--------------------------------------------
    logic cur_on;
    logic valid;
    always_ff @(posedge I_MCLK or posedge I_RST) begin
        if (I_RST) begin
            cur_on <= 1'b1;
            valid <= 1'b1;
        end else begin
            cur_on <= pwr.current_on;
            valid <= pwr.out_valid;
        end
    end

    assign o_CURRENT_OUT_TRUE = out_true;
    assign o_CURRENT_OUT_COMP = out_comp;
    assign o_CLOCK_MODE = mode;
    assign o_PECL_TERM_ON = pecl;
    assign o_CURRENT_ON = cur_on;
    assign o_OUT_VALID = valid;

    //--------------------------------------------
    // Checks
    //--------------------------------------------
    a_codes_sum: assert property (@(posedge I_MCLK) disable iff (I_RST)
        cur_on |-> (o_CURRENT_OUT_TRUE + o_CURRENT_OUT_COMP == `DSL_FULL_CODE))
        else $error("true and comp do not sum to full scale");
    a_latch_delay: assert property (@(posedge I_MCLK) disable iff (I_RST)
        (pwr.current_on && $past(pwr.current_on)) |=> out_true == $past(master))
        else $error("output not updated from latched word");
    a_word_each: assert property (@(posedge I_MCLK) disable iff (I_RST)
        1'b1 |=> master == $past(samp_s2))
        else $error("word not latched on edge");
    a_sleep_off: assert property (@(posedge I_MCLK) disable iff (I_RST)
        !pwr.current_on |=> o_CURRENT_OUT_TRUE == `DSL_ZERO_CODE)
        else $error("current not off in sleep");
    a_pull_down: assert property (@(posedge I_MCLK) disable iff (I_RST)
        !i_SLEEP_DRIVEN |-> ##2 !sleep_lvl)
        else $error("floating sleep not read low");
    a_mode_pecl: assert property (@(posedge I_MCLK) disable iff (I_RST)
        strap_done |-> (pecl == (mode == DSL_CLK_DIFF_PECL)))
        else $error("termination disagrees with mode");
    a_mode_stable: assert property (@(posedge I_MCLK) disable iff (I_RST)
        $past(strap_done) |-> $stable(mode))
        else $error("clock mode changed after capture");
    a_up_wait: assert property (@(posedge I_MCLK) disable iff (I_RST)
        $fell(sleep_lvl) |-> !pwr.out_valid [*8])
        else $error("valid too soon after wake");
endmodule
`default_nettype wire

// ### dsl_sample_latch_tb.sv
// Purpose: self-checking bench for the sample input latch
// Assumes: 25 MHz clock, output four edges behind the latch input
// Notes: all inputs change on the falling edge
`timescale 1ns/1ps
`default_nettype none
`include "dsl_map.svh"
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin fail_count++; \
    $display("ERROR t=%0t got %h exp %h", $time, got, exp); end end
module dsl_sample_latch_tb;
    import dsl_pkg::*;
    logic mclk, rst, sleep, sleep_driven; // Clock, reset and sleep pin
    logic [`DSL_DATA_W-1:0] word, sample, out_true, out_comp; // Sample path
    dsl_strap_t strap; // Strap level
    dsl_clk_mode_t clk_mode; // Selected receiver
    logic pecl_on, current_on, out_valid; // Status outputs
    int fail_count = 0;
    int cmp_count = 0;
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    dsl_sample_src dsl_sample_src_inst (.i_clk(mclk), .i_word(word), .o_sample(sample));
    dsl_sample_latch dsl_sample_latch_inst (
        .I_MCLK(mclk), .I_RST(rst), .i_SAMPLE(sample), .i_SLEEP(sleep),
        .i_SLEEP_DRIVEN(sleep_driven), .i_CLOCK_MODE_STRAP(strap),
        .o_CURRENT_OUT_TRUE(out_true), .o_CURRENT_OUT_COMP(out_comp),
        .o_CLOCK_MODE(clk_mode), .o_PECL_TERM_ON(pecl_on),
        .o_CURRENT_ON(current_on), .o_OUT_VALID(out_valid)
    );
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask
    task automatic do_reset(input dsl_strap_t s);
        rst <= 1'b1;
        strap <= s;
        cyc(16);
        rst <= 1'b0;
        cyc(3);
    endtask
    task automatic finish_test();
        $display("Counts: %0d compares, %0d mismatches", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic test_reset();
        rst <= 1'b1;
        cyc(16);
        `CHK(out_true, `DSL_ZERO_CODE)
        `CHK(out_comp, `DSL_FULL_CODE)
        `CHK(clk_mode, DSL_CLK_SINGLE)
        `CHK(pecl_on, 1'b0)
        `CHK({current_on, out_valid}, 2'h3)
        rst <= 1'b0;
        cyc(3);
        $display("test_reset done");
    endtask
    task automatic test_strap();
        dsl_strap_t s[3] = '{DSL_STRAP_LOW, DSL_STRAP_HIGH, DSL_STRAP_FLOAT};
        dsl_clk_mode_t m[3] = '{DSL_CLK_SINGLE, DSL_CLK_DIFF_HIZ, DSL_CLK_DIFF_PECL};
        for (int i = 0; i < 3; i++) begin
            do_reset(s[i]);
            `CHK(clk_mode, m[i])
            `CHK(pecl_on, (i == 2))
        end
        $display("test_strap done");
    endtask
    task automatic test_stream();
        logic [`DSL_DATA_W-1:0] w[8] = '{12'h000, 12'hfff, 12'h800, 12'h001,
                                         12'h7ff, 12'ha5c, 12'h3c3, 12'hffe};
        for (int i = 0; i < 13; i++) begin
            @(negedge mclk);
            if (i >= 5) begin
                `CHK(out_true, w[i-5])
                `CHK(out_comp, w[i-5] ^ `DSL_FULL_CODE)
            end
            if (i < 8) word <= w[i];
        end
        $display("test_stream done");
    endtask
    task automatic test_sleep();
        int n;
        sleep_driven <= 1'b1;
        sleep <= 1'b1;
        word <= 12'h9ab;
        cyc(4);
        `CHK(out_valid, 1'b0)
        `CHK(current_on, 1'b1)
        cyc(1);
        `CHK(current_on, 1'b0)
        `CHK(out_true, `DSL_ZERO_CODE)
        `CHK(out_comp, `DSL_ZERO_CODE)
        sleep <= 1'b0;
        cyc(10);
        `CHK({current_on, out_valid}, 2'h2)
        n = 10;
        while (out_valid !== 1'b1 && n < 300) begin
            cyc(1);
            n++;
        end
        `CHK((n >= 120 && n <= 135), 1'b1)
        `CHK(out_true, 12'h9ab)
        $display("test_sleep done");
    endtask
    task automatic test_float();
        sleep <= 1'b1;
        sleep_driven <= 1'b0;
        word <= 12'h456;
        cyc(8);
        `CHK({current_on, out_valid}, 2'h3)
        `CHK(out_true, 12'h456)
        sleep_driven <= 1'b1;
        sleep <= 1'b0;
        $display("test_float done");
    endtask
    // Watchdog far beyond the few hundred cycles the run needs
    initial begin
        repeat (5000) @(posedge mclk);
        fail_count++;
        finish_test();
    end
    // Main sequence
    initial begin
        rst = 1'b1;
        word = `DSL_ZERO_CODE;
        sleep = 1'b0;
        sleep_driven = 1'b1;
        strap = DSL_STRAP_LOW;
        test_reset();
        test_strap();
        test_stream();
        test_sleep();
        test_float();
        finish_test();
    end
endmodule
`default_nettype wire

// ### dsl_sample_src.sv
// Purpose: parallel sample source model for the sample input latch
// Assumes: words are requested by the bench
// Notes: the word changes on the falling clock edge only
`timescale 1ns/1ps
`default_nettype none
`include "dsl_map.svh"
module dsl_sample_src (
    input wire logic i_clk,
    input wire logic [`DSL_DATA_W-1:0] i_word,
    output logic [`DSL_DATA_W-1:0] o_sample
);
    // Known word from time zero
    initial o_sample = `DSL_ZERO_CODE;
    // falling edge launch
    // Keeps each change half a cycle away from the latch edge
    always @(negedge i_clk) begin
        o_sample <= i_word;
    end
endmodule
`default_nettype wire
